// ---- core/sse_pkg.sv ----
package sse_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_WATCHDOG = 8'h0c;
  localparam logic [7:0] OFF_FILE = 8'h80;
  localparam int FILE_SEL_BIT = 7;
  localparam int FILE_IDX_LSB = 2;
  localparam int FILE_IDX_W = 5;
  // instruction word
  localparam int INSTR_W = 12;
  localparam logic [11:0] OPC_HALT = 12'h003;
  localparam logic [11:0] OPC_SUB_MASK = 12'hfc0;
  localparam logic [11:0] OPC_SUB_VAL = 12'h080;
  localparam int SUB_DEST_BIT = 5;
  localparam int SUB_FADDR_LSB = 0;
  // status bit positions
  localparam int ST_C = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z = 2;
  localparam int ST_POWERDOWN = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_W = 5;
  localparam logic [4:0] ST_RESET = 5'h18;
  // watchdog register layout
  localparam int WATCHDOG_CNT_LSB = 0;
  localparam int WATCHDOG_PRE_LSB = 8;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
endpackage

// ---- core/sse_alu.sv ----
`timescale 1ns/1ps
module sse_alu (
  input wire logic [7:0] file_i,
  input wire logic [7:0] acc_i,
  output logic [7:0] res_o,
  output logic carry_o,
  output logic digit_carry_o,
  output logic zero_o
);
  logic [8:0] diff;
  logic [4:0] low;
  // two's complement: f + ~w + 1, carry out means no borrow
  assign diff = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001; // RL4
  assign low = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
  assign res_o = diff[7:0];
  assign carry_o = diff[8]; // RL6
  assign digit_carry_o = low[4]; // RL6
  assign zero_o = (diff[7:0] == 8'h00); // RL6
endmodule

// ---- core/sse_exec.sv ----
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Overview of operation
// [RL1] halt word stops the oscillator until a wake-up event arrives
// [RL2] halt clears the watchdog counter and its prescaler
// [RL3] halt sets time-out bit, clears power-down bit, other flags untouched
// [RL4] subtract computes file register minus accumulator, single cycle
// [RL5] destination bit zero writes accumulator, one writes the file register
// [RL6] subtract updates carry (no borrow), digit carry and zero flags
module sse_exec #(
  parameter int FILE_DEPTH = 32,
  parameter int PRESC_W = 8
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic wake_i,
  output logic osc_en_o,
  output logic halted_o
);
  if (FILE_DEPTH < 1 || FILE_DEPTH > 32 || PRESC_W < 1 || PRESC_W > 8) begin
    $error("sse_exec: unsupported FILE_DEPTH or PRESC_W");
  end

  function automatic logic is_halt(input logic [11:0] w);
    return w == sse_pkg::OPC_HALT;
  endfunction

  function automatic logic is_sub(input logic [11:0] w);
    return (w & sse_pkg::OPC_SUB_MASK) == sse_pkg::OPC_SUB_VAL;
  endfunction

  function automatic logic is_file(input logic [7:0] a);
    return a[sse_pkg::FILE_SEL_BIT] &&
      (32'(a[sse_pkg::FILE_IDX_LSB +: sse_pkg::FILE_IDX_W]) < FILE_DEPTH);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // bus slave
  logic ap_valid;
  logic dp_wr_q;
  logic dp_rd_q;
  logic rd_done_q;
  logic [7:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_word;
  logic [4:0] dp_idx;

  assign ap_valid = hsel_i && htrans_i[1] && hready_i;
  assign dp_idx = dp_addr_q[sse_pkg::FILE_IDX_LSB +: sse_pkg::FILE_IDX_W];
  // reads take one wait state so the returned word comes from a flip-flop
  assign hreadyout_o = !(dp_rd_q && !rd_done_q);
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else if (hreadyout_o) begin
      dp_wr_q <= ap_valid && hwrite_i;
      dp_rd_q <= ap_valid && !hwrite_i;
      if (ap_valid) begin
        dp_addr_q <= haddr_i[7:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_done_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      rd_done_q <= dp_rd_q && !rd_done_q;
      if (dp_rd_q && !rd_done_q) begin
        hrdata_q <= rd_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] file_q [FILE_DEPTH];
  logic [7:0] acc_q;
  logic [sse_pkg::ST_W-1:0] st_q;
  logic [7:0] watchdog_counter_q;
  logic [PRESC_W-1:0] presc_q;
  logic halt_q;
  logic wake_meta_q;
  logic wake_s_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_file(dp_addr_q)) begin
      rd_word[7:0] = file_q[dp_idx];
    end else begin
      unique case (dp_addr_q)
        sse_pkg::OFF_ACC: rd_word[7:0] = acc_q;
        sse_pkg::OFF_STATUS: rd_word[sse_pkg::ST_W-1:0] = st_q;
        sse_pkg::OFF_WATCHDOG: begin
          rd_word[sse_pkg::WATCHDOG_CNT_LSB +: 8] = watchdog_counter_q;
          rd_word[sse_pkg::WATCHDOG_PRE_LSB +: PRESC_W] = presc_q;
        end
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decode and execute
  logic [11:0] instr;
  logic wr_instr;
  logic do_halt;
  logic do_sub;
  logic sub_dest;
  logic [4:0] sub_f;
  logic [7:0] f_op;
  logic [7:0] sub_res;
  logic sub_c;
  logic sub_digit;
  logic sub_z;
  logic bus_wr_file;

  assign instr = hwdata_i[sse_pkg::INSTR_W-1:0];
  // an oscillator that is stopped executes nothing
  assign wr_instr = dp_wr_q && (dp_addr_q == sse_pkg::OFF_INSTR) && !halt_q;
  assign do_halt = wr_instr && is_halt(instr); // RL1
  assign do_sub = wr_instr && is_sub(instr); // RL4
  assign sub_dest = instr[sse_pkg::SUB_DEST_BIT];
  assign sub_f = instr[sse_pkg::SUB_FADDR_LSB +: 5];
  assign f_op = (32'(sub_f) < FILE_DEPTH) ? file_q[sub_f] : 8'h00;
  assign bus_wr_file = dp_wr_q && is_file(dp_addr_q);

  sse_alu u_alu (
    .file_i(f_op),
    .acc_i(acc_q),
    .res_o(sub_res),
    .carry_o(sub_c),
    .digit_carry_o(sub_digit),
    .zero_o(sub_z)
  );

  for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        file_q[i] <= 8'h00;
      end else if (do_sub && sub_dest && 32'(sub_f) == i) begin
        file_q[i] <= sub_res; // RL5
      end else if (bus_wr_file && 32'(dp_idx) == i) begin
        file_q[i] <= hwdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= 8'h00;
    end else if (do_sub && !sub_dest) begin
      acc_q <= sub_res; // RL5
    end else if (dp_wr_q && dp_addr_q == sse_pkg::OFF_ACC) begin
      acc_q <= hwdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= sse_pkg::ST_RESET;
    end else if (do_sub) begin
      st_q[sse_pkg::ST_C] <= sub_c; // RL6
      st_q[sse_pkg::ST_DIGIT] <= sub_digit; // RL6
      st_q[sse_pkg::ST_Z] <= sub_z; // RL6
    end else if (do_halt) begin
      st_q[sse_pkg::ST_TIMEOUT] <= 1'b1; // RL3
      st_q[sse_pkg::ST_POWERDOWN] <= 1'b0; // RL3
    end else if (dp_wr_q && dp_addr_q == sse_pkg::OFF_STATUS) begin
      st_q <= hwdata_i[sse_pkg::ST_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_counter_q <= sse_pkg::WATCHDOG_CLEAR;
      presc_q <= '0;
    end else if (do_halt) begin
      watchdog_counter_q <= sse_pkg::WATCHDOG_CLEAR; // RL2
      presc_q <= '0; // RL2
    end else begin
      presc_q <= presc_q + 1'b1;
      if (&presc_q) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_meta_q <= 1'b0;
      wake_s_q <= 1'b0;
    end else begin
      wake_meta_q <= wake_i;
      wake_s_q <= wake_meta_q;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      halt_q <= 1'b0;
    end else if (do_halt) begin
      halt_q <= 1'b1; // RL1
    end else if (wake_s_q) begin
      halt_q <= 1'b0; // RL1
    end
  end

  assign osc_en_o = !halt_q;
  assign halted_o = halt_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence halt_issued;
    do_halt ##1 (halt_q && !osc_en_o);
  endsequence

  sequence sub_issued;
    do_sub;
  endsequence

  halt_entry_a: assert property (do_halt |-> halt_issued) // RL1
    else $error("halt did not stop the oscillator");
  halt_hold_a: assert property (halt_q && !wake_s_q |=> halt_q) // RL1
    else $error("halt left without a wake-up");
  watchdog_clear_a: assert property ( // RL2
    do_halt |=> watchdog_counter_q == sse_pkg::WATCHDOG_CLEAR &&
    presc_q == '0)
    else $error("watchdog not cleared by halt");
  status_halt_a: assert property ( // RL3
    do_halt |=> st_q[sse_pkg::ST_TIMEOUT] &&
    !st_q[sse_pkg::ST_POWERDOWN] && $stable(st_q[2:0]))
    else $error("halt status bits wrong");
  sub_value_a: assert property ( // RL4
    do_sub && !sub_dest |=> acc_q == 8'($past(f_op) - $past(acc_q)))
    else $error("subtract result wrong");
  sub_file_a: assert property ( // RL5
    do_sub && sub_dest && 32'(sub_f) < FILE_DEPTH |=>
    file_q[$past(sub_f)] == 8'($past(f_op) - $past(acc_q)) &&
    $stable(acc_q))
    else $error("subtract did not write the file register");
  sub_flags_a: assert property ( // RL6
    sub_issued |=>
    st_q[sse_pkg::ST_C] == ($past(f_op) >= $past(acc_q)) &&
    st_q[sse_pkg::ST_DIGIT] == ($past(f_op[3:0]) >= $past(acc_q[3:0])) &&
    st_q[sse_pkg::ST_Z] == ($past(f_op) == $past(acc_q)))
    else $error("subtract flags wrong");
  rd_wait_a: assert property (dp_rd_q && !rd_done_q |-> !hreadyout_o ##1
    hreadyout_o && hrdata_o == $past(rd_word))
    else $error("read answer timing wrong");
endmodule

// ---- dv/sse_exec_bench.sv ----
`timescale 1ns/1ps
module sse_exec_bench;
  logic clock_i;
  logic rst_n_i;
  logic hsel_i;
  logic [31:0] haddr_i;
  logic [1:0] htrans_i;
  logic hwrite_i;
  logic [2:0] hsize_i;
  logic [31:0] hwdata_i;
  logic hready_i;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic wake_i;
  logic osc_en_o;
  logic halted_o;
  int mismatches;
  int n_compared;
  logic [31:0] rd;
  logic [7:0] acc_q;
  logic [4:0] st_q;
  assign hready_i = hreadyout_o;
  sse_exec uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .wake_i(wake_i), .osc_en_o(osc_en_o), .halted_o(halted_o));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // waits for the edge at which hready is sampled high
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clock_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        conclude();
      end
      @(posedge clock_i);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
    hsel_i <= 1'b1;
    haddr_i <= {24'h000000, a};
    hwrite_i <= w;
    htrans_i <= sse_pkg::HTRANS_NONSEQ_BIT;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_rdy();
    r = hrdata_o;
    chk({31'h0, hresp_o}, 32'h0);
  endtask
  task automatic sub(input logic [4:0] f, input logic [7:0] fv,
                     input logic [7:0] av, input logic d);
    logic [7:0] r;
    logic [7:0] fa;
    r = fv - av;
    fa = sse_pkg::OFF_FILE + {1'b0, f, 2'b00};
    xfer(1'b1, fa, {24'h0, fv}, rd);
    xfer(1'b1, sse_pkg::OFF_ACC, {24'h0, av}, rd);
    xfer(1'b1, sse_pkg::OFF_INSTR, {26'h2, d, f}, rd);
    st_q = {st_q[4:3], r == 8'h00, fv[3:0] >= av[3:0], fv >= av};
    acc_q = d ? av : r;
    xfer(1'b0, fa, 32'h0, rd);
    chk(rd, {24'h0, d ? r : fv});
    xfer(1'b0, sse_pkg::OFF_ACC, 32'h0, rd);
    chk(rd, {24'h0, acc_q});
    xfer(1'b0, sse_pkg::OFF_STATUS, 32'h0, rd);
    chk(rd, {27'h0, st_q});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hsize_i = 3'h2;
    hwdata_i = 32'h0;
    wake_i = 1'b0;
    mismatches = 0;
    n_compared = 0;
    st_q = 5'h18;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    xfer(1'b0, sse_pkg::OFF_STATUS, 32'h0, rd);
    chk(rd, 32'h18);
    xfer(1'b0, 8'h40, 32'h0, rd);
    chk(rd, 32'h0);
    $display("test reset done");
    sub(5'd1, 8'h03, 8'h02, 1'b1);
    sub(5'd2, 8'h02, 8'h02, 1'b1);
    sub(5'd3, 8'h01, 8'h02, 1'b0);
    sub(5'd31, 8'h10, 8'h01, 1'b0);
    $display("test subtract done");
    repeat (300) @(posedge clock_i);
    xfer(1'b0, sse_pkg::OFF_WATCHDOG, 32'h0, rd);
    chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
    xfer(1'b1, sse_pkg::OFF_INSTR, {20'h0, sse_pkg::OPC_HALT}, rd);
    @(posedge clock_i);
    chk({30'h0, osc_en_o, halted_o}, 32'h1);
    xfer(1'b0, sse_pkg::OFF_WATCHDOG, 32'h0, rd);
    chk({31'h0, rd[7:0] == 8'h00 && rd[15:8] < 8'h08}, 32'h1);
    xfer(1'b0, sse_pkg::OFF_STATUS, 32'h0, rd);
    st_q[4:3] = 2'b10;
    chk(rd, {27'h0, st_q});
    // a word written while halted must not execute
    xfer(1'b1, sse_pkg::OFF_INSTR, 32'h081, rd);
    xfer(1'b0, sse_pkg::OFF_ACC, 32'h0, rd);
    chk(rd, {24'h0, acc_q});
    chk({31'h0, halted_o}, 32'h1);
    @(posedge clock_i);
    wake_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    wake_i <= 1'b0;
    @(posedge clock_i);
    chk({30'h0, osc_en_o, halted_o}, 32'h2);
    $display("test halt done");
    sub(5'd4, 8'h00, 8'hff, 1'b1);
    $display("test resume done");
    conclude();
  end
endmodule
